// ==== rtl/adrc_pkg.sv ====
// Constants, types and timing for the asynchronous dynamic memory controller.
// Assumes a single 25 MHz system clock; all pin timings are whole cycles of it.
`default_nettype none
package adrc_pkg;
  // ==========================================================================
  // Clock and timing
  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned CLK_NS = 40;
  localparam int unsigned PWRUP_US = 100;
  localparam int unsigned PWRUP_CYC = PWRUP_US * CLK_MHZ;
  localparam int unsigned INIT_REFRESH_CNT = 8;
  localparam int unsigned REF_INTERVAL_NS = 15600;
  localparam int unsigned REF_INTERVAL_CYC = REF_INTERVAL_NS / CLK_NS;
  localparam int unsigned SELF_LOW_US = 100;
  localparam int unsigned SELF_LOW_CYC = SELF_LOW_US * CLK_MHZ;
  localparam int unsigned FULL_REFRESH_CNT = 1024;
  localparam int unsigned CSR_NS = 10;
  localparam int unsigned CSR_CYC = (CSR_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RAS_LOW_NS = 80;
  localparam int unsigned RAS_LOW_CYC = (RAS_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RAS_PRE_NS = 60;
  localparam int unsigned RAS_PRE_CYC = (RAS_PRE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned ACCESS_NS = 80;
  localparam int unsigned ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SELF_PRE_NS = 150;
  localparam int unsigned SELF_PRE_CYC = (SELF_PRE_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================================
  // Widths
  localparam int unsigned ROW_W = 10;
  localparam int unsigned COL_W = 8;
  localparam int unsigned ADDR_W = ROW_W + COL_W;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned REFN_W = 11;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [REFN_W-1:0] REFN_ZERO = 11'h000;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    ADRC_OP_READ,
    ADRC_OP_WRITE,
    ADRC_OP_SELF_ENTER,
    ADRC_OP_SELF_EXIT
  } adrc_op_t;

  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic upper_byte_write_n;
    logic lower_byte_write_n;
    logic oe_n;
    logic [ROW_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe;
  } adrc_pins_t;

  typedef enum {
    ST_PWRUP, ST_INIT_CAS, ST_INIT_RAS, ST_INIT_PRE, ST_IDLE,
    ST_ROW, ST_COL, ST_RDWAIT, ST_WRDONE, ST_PRE,
    ST_REF_CAS, ST_REF_RAS, ST_SELF_CAS, ST_SELF_HOLD, ST_SELF, ST_SELF_PRE
  } adrc_state_t;
endpackage : adrc_pkg
`default_nettype wire

// ==== rtl/adrc_ctrl.sv ====
// Host-side controller for an asynchronous 16-bit dynamic memory with multiplexed address.
// Assumes the memory pins sit on this clock; read data is sampled through three flip-flops.
//
// What this block does
// - Wait 100 us after power-up, then eight refresh cycles before any access.
// - Initialisation refreshes are column-first, matching normal column-first refresh.
// - Output state is undefined unless write timing is clearly early or late.
// - Long row-to-column delays make column or address access time the limit.
// - Output enable is off before this side drives write data.
// - Read ends with read hold met at column strobe rise.
// - Both byte write strobes fall together; never staggered.
// - Byte strobe timing counts from earlier fall and later rise.
// - Each byte write strobe meets pulse, lead, setup and hold timing alone.
// - Both bytes always run the same operation in one cycle.
// - Byte strobes are never separated, so precharge spacing is moot.
// - One column-first refresh within 15.6 us around self-refresh exit and entry.
// - Distributed column-first refresh every 15.6 us before entry and after exit.
// - All rows are refreshed between a self-refresh exit and the next entry.
// - Once output enable goes low, it stays low until read data is taken.
// - Self refresh entry holds row strobe low at least 100 us.
// - Column strobe falls at least 10 ns before row strobe for refresh.
`default_nettype none
module adrc_ctrl (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic req_valid_i,
  input wire adrc_pkg::adrc_op_t req_op_i,
  input wire logic [adrc_pkg::ADDR_W-1:0] req_addr_i,
  input wire logic [adrc_pkg::DATA_W-1:0] req_wdata_i,
  input wire logic [1:0] req_byte_en_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [adrc_pkg::DATA_W-1:0] rsp_rdata_o,
  output logic init_done_o,
  output logic self_refresh_o,
  output logic ras_n_o,
  output logic cas_n_o,
  output logic upper_byte_write_n_o,
  output logic lower_byte_write_n_o,
  output logic oe_n_o,
  output logic [adrc_pkg::ROW_W-1:0] addr_o,
  output logic [adrc_pkg::DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  input wire logic [adrc_pkg::DATA_W-1:0] dq_i
);
  // ==========================================================================
  // State
  typedef struct packed {
    adrc_pkg::adrc_state_t st;
    adrc_pkg::adrc_pins_t pins;
    logic [adrc_pkg::CNT_W-1:0] wait_cnt;
    logic [adrc_pkg::CNT_W-1:0] ref_cnt;
    logic [adrc_pkg::REFN_W-1:0] refn;
    logic ref_due;
    logic full_done;
    logic is_write;
    logic [adrc_pkg::ADDR_W-1:0] addr;
    logic [adrc_pkg::DATA_W-1:0] wdata;
    logic [1:0] ben;
    logic ready;
    logic rsp_valid;
    logic [adrc_pkg::DATA_W-1:0] rdata;
    logic init_done;
    logic self_on;
    logic [adrc_pkg::DATA_W-1:0] dq_s1;
    logic [adrc_pkg::DATA_W-1:0] dq_s2;
    logic [adrc_pkg::DATA_W-1:0] dq_s3;
  } adrc_ctrl_state_t;

  adrc_ctrl_state_t s_r;
  adrc_ctrl_state_t s_nxt;

  localparam adrc_pkg::adrc_pins_t PINS_IDLE = '{
    ras_n: 1'b1, cas_n: 1'b1, upper_byte_write_n: 1'b1, lower_byte_write_n: 1'b1,
    oe_n: 1'b1, addr: '0, dq_out: '0, dq_oe: 1'b0};
  localparam logic [adrc_pkg::CNT_W-1:0] PWRUP_C = adrc_pkg::CNT_W'(adrc_pkg::PWRUP_CYC);
  localparam logic [adrc_pkg::CNT_W-1:0] SELF_C = adrc_pkg::CNT_W'(adrc_pkg::SELF_LOW_CYC);
  localparam logic [adrc_pkg::CNT_W-1:0] REF_C = adrc_pkg::CNT_W'(adrc_pkg::REF_INTERVAL_CYC);
  localparam logic [adrc_pkg::CNT_W-1:0] CSR_C = adrc_pkg::CNT_W'(adrc_pkg::CSR_CYC);
  localparam logic [adrc_pkg::CNT_W-1:0] RASL_C = adrc_pkg::CNT_W'(adrc_pkg::RAS_LOW_CYC);
  localparam logic [adrc_pkg::CNT_W-1:0] PRE_C = adrc_pkg::CNT_W'(adrc_pkg::RAS_PRE_CYC);
  localparam logic [adrc_pkg::CNT_W-1:0] ACC_C = adrc_pkg::CNT_W'(adrc_pkg::ACCESS_CYC);
  localparam logic [adrc_pkg::CNT_W-1:0] SPRE_C = adrc_pkg::CNT_W'(adrc_pkg::SELF_PRE_CYC);
  localparam logic [adrc_pkg::CNT_W-1:0] ONE_C = 16'h0001;
  localparam logic [adrc_pkg::REFN_W-1:0] INIT_N = adrc_pkg::REFN_W'(adrc_pkg::INIT_REFRESH_CNT);
  localparam logic [adrc_pkg::REFN_W-1:0] FULL_N = adrc_pkg::REFN_W'(adrc_pkg::FULL_REFRESH_CNT);
  localparam logic [adrc_pkg::REFN_W-1:0] ONE_N = 11'h001;

  logic wait_over;
  assign wait_over = (s_r.wait_cnt == adrc_pkg::CNT_ZERO);

  // ==========================================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.rsp_valid = 1'b0;
    s_nxt.ready = 1'b0;
    // Pin data passes three flip-flops; only the settled copy is read below.
    s_nxt.dq_s1 = dq_i;
    s_nxt.dq_s2 = s_r.dq_s1;
    s_nxt.dq_s3 = s_r.dq_s2;
    if (!wait_over) begin
      s_nxt.wait_cnt = s_r.wait_cnt - ONE_C;
    end
    // The periodic refresh request keeps every row refreshed in normal operation.
    if (s_r.init_done && !s_r.self_on) begin
      if (s_r.ref_cnt == adrc_pkg::CNT_ZERO) begin
        s_nxt.ref_cnt = REF_C;
        s_nxt.ref_due = 1'b1;
      end else begin
        s_nxt.ref_cnt = s_r.ref_cnt - ONE_C;
      end
    end
    case (s_r.st)
      adrc_pkg::ST_PWRUP: begin
        if (wait_over) begin
          s_nxt.refn = INIT_N;
          s_nxt.st = adrc_pkg::ST_INIT_CAS;
        end
      end
      adrc_pkg::ST_INIT_CAS: begin
        // Initialisation uses the same column-first refresh as normal operation.
        s_nxt.pins.cas_n = 1'b0;
        s_nxt.wait_cnt = CSR_C;
        s_nxt.st = adrc_pkg::ST_INIT_RAS;
      end
      adrc_pkg::ST_INIT_RAS: begin
        if (wait_over) begin
          s_nxt.pins.ras_n = 1'b0;
          s_nxt.wait_cnt = RASL_C;
          s_nxt.st = adrc_pkg::ST_INIT_PRE;
        end
      end
      adrc_pkg::ST_INIT_PRE: begin
        if (wait_over && !s_r.pins.ras_n) begin
          s_nxt.pins = PINS_IDLE;
          s_nxt.wait_cnt = PRE_C;
          s_nxt.refn = s_r.refn - ONE_N;
        end else if (wait_over && s_r.pins.ras_n) begin
          if (s_r.refn == adrc_pkg::REFN_ZERO) begin
            s_nxt.init_done = 1'b1;
            s_nxt.ref_cnt = REF_C;
            s_nxt.ready = 1'b1;
            s_nxt.st = adrc_pkg::ST_IDLE;
          end else begin
            s_nxt.st = adrc_pkg::ST_INIT_CAS;
          end
        end
      end
      adrc_pkg::ST_IDLE: begin
        // Ready stays low while a refresh is due, so a request is never shown ready and then passed over.
        s_nxt.ready = !s_nxt.ref_due;
        if (s_r.ref_due) begin
          s_nxt.ready = 1'b0;
          // A new expiry in this very cycle keeps the flag set.
          s_nxt.ref_due = (s_r.ref_cnt == adrc_pkg::CNT_ZERO);
          s_nxt.pins.cas_n = 1'b0;
          s_nxt.wait_cnt = CSR_C;
          s_nxt.st = adrc_pkg::ST_REF_CAS;
        end else if (s_r.ready && req_valid_i) begin
          s_nxt.ready = 1'b0;
          s_nxt.addr = req_addr_i;
          s_nxt.wdata = req_wdata_i;
          // A write with no byte enabled would leave both bytes reading; it is turned into a read.
          s_nxt.is_write = (req_op_i == adrc_pkg::ADRC_OP_WRITE) && (req_byte_en_i != 2'h0);
          s_nxt.ben = req_byte_en_i;
          if (req_op_i == adrc_pkg::ADRC_OP_SELF_ENTER) begin
            // Entry needs a full refresh since the last exit; no extra refresh is issued just before it.
            if (s_r.full_done) begin
              s_nxt.pins.cas_n = 1'b0;
              s_nxt.wait_cnt = CSR_C;
              s_nxt.st = adrc_pkg::ST_SELF_CAS;
            end else begin
              s_nxt.ready = !s_nxt.ref_due;
            end
          end else if (req_op_i == adrc_pkg::ADRC_OP_SELF_EXIT) begin
            s_nxt.ready = !s_nxt.ref_due;
          end else begin
            s_nxt.pins.addr = req_addr_i[adrc_pkg::ADDR_W-1:adrc_pkg::COL_W];
            s_nxt.st = adrc_pkg::ST_ROW;
          end
        end
      end
      adrc_pkg::ST_ROW: begin
        s_nxt.pins.ras_n = 1'b0;
        s_nxt.st = adrc_pkg::ST_COL;
      end
      adrc_pkg::ST_COL: begin
        s_nxt.pins.addr = {2'h0, s_r.addr[adrc_pkg::COL_W-1:0]};
        if (s_r.is_write) begin
          // Early write: strobes and data settle before the column strobe falls.
          s_nxt.pins.oe_n = 1'b1;
          s_nxt.pins.upper_byte_write_n = 1'b0;
          s_nxt.pins.lower_byte_write_n = 1'b0;
          s_nxt.pins.dq_out = s_r.wdata;
          s_nxt.pins.dq_oe = 1'b1;
          s_nxt.wait_cnt = RASL_C;
          s_nxt.st = adrc_pkg::ST_WRDONE;
        end else begin
          s_nxt.pins.oe_n = 1'b0;
          s_nxt.wait_cnt = ACC_C + ONE_C + ONE_C;
          s_nxt.st = adrc_pkg::ST_RDWAIT;
        end
      end
      adrc_pkg::ST_WRDONE: begin
        // Column strobe falls one cycle after both byte strobes, which stay low together.
        s_nxt.pins.cas_n = 1'b0;
        if (wait_over) begin
          s_nxt.pins = PINS_IDLE;
          s_nxt.wait_cnt = PRE_C;
          s_nxt.st = adrc_pkg::ST_PRE;
        end
      end
      adrc_pkg::ST_RDWAIT: begin
        s_nxt.pins.cas_n = 1'b0;
        // Waiting out the longest access path plus two cycles of the three-flop input synchroniser.
        if (wait_over) begin
          s_nxt.rdata = s_r.dq_s3;
          s_nxt.rsp_valid = 1'b1;
          s_nxt.pins = PINS_IDLE;
          s_nxt.wait_cnt = PRE_C;
          s_nxt.st = adrc_pkg::ST_PRE;
        end
      end
      adrc_pkg::ST_PRE: begin
        if (wait_over) begin
          s_nxt.ready = !s_nxt.ref_due;
          s_nxt.st = adrc_pkg::ST_IDLE;
        end
      end
      adrc_pkg::ST_REF_CAS: begin
        if (wait_over && s_r.pins.ras_n) begin
          s_nxt.pins.ras_n = 1'b0;
          s_nxt.wait_cnt = RASL_C;
        end else if (wait_over) begin
          s_nxt.pins = PINS_IDLE;
          s_nxt.wait_cnt = PRE_C;
          if (s_r.refn == FULL_N - ONE_N) begin
            s_nxt.full_done = 1'b1;
          end else begin
            s_nxt.refn = s_r.refn + ONE_N;
          end
          s_nxt.st = adrc_pkg::ST_PRE;
        end
      end
      adrc_pkg::ST_SELF_CAS: begin
        if (wait_over) begin
          s_nxt.pins.ras_n = 1'b0;
          s_nxt.wait_cnt = SELF_C;
          s_nxt.self_on = 1'b1;
          s_nxt.st = adrc_pkg::ST_SELF_HOLD;
        end
      end
      adrc_pkg::ST_SELF_HOLD: begin
        if (wait_over) begin
          s_nxt.ready = 1'b1;
          s_nxt.st = adrc_pkg::ST_SELF;
        end
      end
      adrc_pkg::ST_SELF: begin
        s_nxt.ready = 1'b1;
        if (s_r.ready && req_valid_i && req_op_i == adrc_pkg::ADRC_OP_SELF_EXIT) begin
          s_nxt.ready = 1'b0;
          s_nxt.pins = PINS_IDLE;
          s_nxt.wait_cnt = SPRE_C;
          s_nxt.st = adrc_pkg::ST_SELF_PRE;
        end
      end
      adrc_pkg::ST_SELF_PRE: begin
        if (wait_over) begin
          // A refresh follows exit at once, and a new full sweep of all rows starts.
          s_nxt.self_on = 1'b0;
          s_nxt.full_done = 1'b0;
          s_nxt.refn = adrc_pkg::REFN_ZERO;
          s_nxt.ref_cnt = REF_C;
          s_nxt.ref_due = 1'b1;
          s_nxt.st = adrc_pkg::ST_IDLE;
        end
      end
      default: begin
        s_nxt.st = adrc_pkg::ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_r <= '0;
      s_r.st <= adrc_pkg::ST_PWRUP;
      s_r.pins <= PINS_IDLE;
      s_r.wait_cnt <= PWRUP_C;
      s_r.full_done <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign req_ready_o = s_r.ready;
  assign rsp_valid_o = s_r.rsp_valid;
  assign rsp_rdata_o = s_r.rdata;
  assign init_done_o = s_r.init_done;
  assign self_refresh_o = s_r.self_on;
  assign ras_n_o = s_r.pins.ras_n;
  assign cas_n_o = s_r.pins.cas_n;
  assign upper_byte_write_n_o = s_r.pins.upper_byte_write_n;
  assign lower_byte_write_n_o = s_r.pins.lower_byte_write_n;
  assign oe_n_o = s_r.pins.oe_n;
  assign addr_o = s_r.pins.addr;
  assign dq_o = s_r.pins.dq_out;
  assign dq_oe_o = s_r.pins.dq_oe;
endmodule : adrc_ctrl
`default_nettype wire

// ==== tb/adrc_ctrl_monitor.sv ====
// Checker for the controller's strobe, refresh and request timing.
// Assumes it is bound to adrc_ctrl and sees only that module's ports.
`default_nettype none
module adrc_ctrl_monitor (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic req_valid_i,
  input wire adrc_pkg::adrc_op_t req_op_i,
  input wire logic req_ready_o,
  input wire logic rsp_valid_o,
  input wire logic init_done_o,
  input wire logic self_refresh_o,
  input wire logic ras_n_o,
  input wire logic cas_n_o,
  input wire logic upper_byte_write_n_o,
  input wire logic lower_byte_write_n_o,
  input wire logic oe_n_o,
  input wire logic dq_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // Helper counters
  logic ras_q_r;
  logic [15:0] up_r;
  logic [15:0] low_r;
  logic [15:0] gap_r;
  logic [3:0] nref_r;
  logic ref_w;
  logic rd_w;
  assign ref_w = ras_q_r && !ras_n_o && !cas_n_o;
  assign rd_w = req_valid_i && req_ready_o && init_done_o && !self_refresh_o && req_op_i == adrc_pkg::ADRC_OP_READ;
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ras_q_r <= 1'b1;
      up_r <= 16'h0000;
      low_r <= 16'h0000;
      gap_r <= 16'h0000;
      nref_r <= 4'h0;
    end else begin
      ras_q_r <= ras_n_o;
      up_r <= (up_r == 16'hffff) ? up_r : up_r + 16'h0001;
      low_r <= ras_n_o ? 16'h0000 : low_r + 16'h0001;
      gap_r <= (ref_w || self_refresh_o || !init_done_o) ? 16'h0000 : gap_r + 16'h0001;
      nref_r <= (ref_w && nref_r != 4'hf) ? nref_r + 4'h1 : nref_r;
    end
  end
  // ====================
  // Assertions
  default clocking mon_cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);
  a_init_wait: assert property ($fell(ras_n_o) |-> up_r >= 16'h09c4)
    else $error("row strobe before power-up wait");
  a_init_count: assert property ($rose(init_done_o) |-> nref_r >= 4'h8)
    else $error("too few initial refreshes");
  a_init_col_first: assert property (!init_done_o && $fell(ras_n_o) |-> !cas_n_o)
    else $error("initial refresh not column first");
  a_cas_leads_ras: assert property ($fell(ras_n_o) && !cas_n_o |-> !$past(cas_n_o))
    else $error("column strobe lead too short");
  a_byte_strobes_same: assert property (upper_byte_write_n_o == lower_byte_write_n_o)
    else $error("byte write strobes differ");
  a_oe_off_drive: assert property (dq_oe_o |-> oe_n_o)
    else $error("output enable low while driving data");
  a_early_write: assert property ($fell(cas_n_o) && !upper_byte_write_n_o |-> !$past(upper_byte_write_n_o) && dq_oe_o)
    else $error("write strobe or data late");
  a_oe_held: assert property ($fell(oe_n_o) |-> (!oe_n_o) [*3])
    else $error("output enable toggled early");
  a_read_answer: assert property (rd_w |-> ##[4:12] rsp_valid_o)
    else $error("read answer missing");
  a_self_low: assert property ($rose(ras_n_o) && self_refresh_o |-> low_r >= 16'h09c4)
    else $error("self refresh row low too short");
  a_refresh_gap: assert property (gap_r <= 16'h0196)
    else $error("refresh interval exceeded");
endmodule : adrc_ctrl_monitor
`default_nettype wire

// ==== tb/adrc_mem_model.sv ====
// Behavioural model of the 16-bit dynamic memory on the controller's pins.
// Assumes a host drives all strobes; the model has no clock of its own.
`default_nettype none
module adrc_mem_model #(
  parameter int ACC_NS = 30
) (
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic upper_byte_write_n_i,
  input wire logic lower_byte_write_n_i,
  input wire logic oe_n_i,
  input wire logic [9:0] addr_i,
  input wire logic [15:0] ctl_dq_i,
  input wire logic ctl_dq_oe_i,
  output logic [15:0] bus_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:262143];
  logic [9:0] row_r;
  logic [7:0] col_r;
  logic [15:0] last_r = 16'h5a5a;
  logic drive_r = 1'b0;
  wire logic wr_n = upper_byte_write_n_i & lower_byte_write_n_i;
  // ====================
  // Access
  always @(negedge ras_n_i) if (cas_n_i) row_r = addr_i;
  always @(negedge cas_n_i) begin
    if (!ras_n_i) begin
      col_r = addr_i[7:0];
      if (!wr_n) begin
        mem[{row_r, col_r}] = ctl_dq_i;
      end else begin
        #(ACC_NS);
        drive_r = !cas_n_i && !oe_n_i;
      end
    end
  end
  // The first falling write strobe latches the word, so one merged strobe is enough.
  always @(negedge wr_n) if (!cas_n_i && !ras_n_i) mem[{row_r, col_r}] = ctl_dq_i;
  always @(posedge cas_n_i or posedge oe_n_i) drive_r = 1'b0;
  always @(negedge drive_r) last_r = mem[{row_r, col_r}];
  // An idle bus shows the inverse of the last word, so stale data never passes.
  assign bus_o = ctl_dq_oe_i ? ctl_dq_i : (drive_r ? mem[{row_r, col_r}] : ~last_r);
endmodule : adrc_mem_model
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the dynamic memory controller.
// Assumes the memory model and the checker are compiled before it.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i;
  logic sys_rst_i = 1'b1;
  logic req_valid_i = 1'b0;
  adrc_pkg::adrc_op_t req_op_i = adrc_pkg::ADRC_OP_READ;
  logic [17:0] req_addr_i = 18'h00000;
  logic [15:0] req_wdata_i = 16'h0000;
  logic [1:0] req_byte_en_i = 2'h0;
  logic req_ready_o, rsp_valid_o, init_done_o, self_refresh_o, ras_n_o, cas_n_o;
  logic upper_byte_write_n_o, lower_byte_write_n_o, oe_n_o, dq_oe_o;
  logic [15:0] rsp_rdata_o, dq_o, dq_i;
  logic [9:0] addr_o;
  int n_fail = 0;
  int check_count = 0;
  int seed = 32'h4e38436a;
  logic [15:0] exp_mem [logic [17:0]];
  logic [17:0] used [$];
  adrc_ctrl adrc_ctrl_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .req_valid_i(req_valid_i), .req_op_i(req_op_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .req_byte_en_i(req_byte_en_i), .req_ready_o(req_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .init_done_o(init_done_o), .self_refresh_o(self_refresh_o),
    .ras_n_o(ras_n_o), .cas_n_o(cas_n_o), .upper_byte_write_n_o(upper_byte_write_n_o),
    .lower_byte_write_n_o(lower_byte_write_n_o), .oe_n_o(oe_n_o), .addr_o(addr_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
    .dq_i(dq_i));
  adrc_mem_model adrc_mem_model_i (.ras_n_i(ras_n_o), .cas_n_i(cas_n_o), .upper_byte_write_n_i(upper_byte_write_n_o),
    .lower_byte_write_n_i(lower_byte_write_n_o), .oe_n_i(oe_n_o), .addr_i(addr_o), .ctl_dq_i(dq_o),
    .ctl_dq_oe_i(dq_oe_o), .bus_o(dq_i));
  // ====================
  // Tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  // Entered at a falling edge; the request is held until a rising edge sees ready.
  task automatic req(input adrc_pkg::adrc_op_t op, input logic [17:0] a, input logic [15:0] d, input logic [1:0] be);
    int n;
    n = 0;
    // One clock edge passes between two requests, so valid is never lowered and raised in one step.
    @(negedge mclk_i);
    req_op_i = op;
    req_addr_i = a;
    req_wdata_i = d;
    req_byte_en_i = be;
    req_valid_i = 1'b1;
    while (req_ready_o !== 1'b1 && n < 4000) begin
      @(negedge mclk_i);
      n++;
    end
    @(negedge mclk_i);
    req_valid_i = 1'b0;
    chk("req_taken", n < 4000, 1'b1);
    if (op == adrc_pkg::ADRC_OP_WRITE && be != 2'h0) begin
      exp_mem[a] = d;
    end else if (op == adrc_pkg::ADRC_OP_READ || op == adrc_pkg::ADRC_OP_WRITE) begin
      n = 0;
      while (rsp_valid_o !== 1'b1 && n < 20) begin
        @(negedge mclk_i);
        n++;
      end
      chk("rsp_seen", n < 20, 1'b1);
      chk("rdata", rsp_rdata_o, exp_mem[a]);
    end
  endtask : req
  // ====================
  // Stimulus
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  initial begin
    #(30000 * 40);
    n_fail++;
    $display("[ERR] watchdog expected done seen hang");
    report_and_stop();
  end
  initial begin
    logic [17:0] a;
    logic [1:0] be;
    int n;
    repeat (10) @(negedge mclk_i);
    sys_rst_i = 1'b0;
    n = 0;
    while (init_done_o !== 1'b1 && n < 4000) begin
      @(negedge mclk_i);
      n++;
    end
    chk("init_wait", n >= 2508, 1'b1);
    // Even steps write (0 twice, then the top word), odd steps read back at random.
    for (int i = 0; i < 40; i++) begin
      be = 2'($random(seed));
      if (i[0]) begin
        a = used[$unsigned($random(seed)) % used.size()];
        req(be[0] ? adrc_pkg::ADRC_OP_READ : adrc_pkg::ADRC_OP_WRITE, a, 16'hffff, 2'h0);
      end else begin
        a = (i < 4) ? 18'h00000 : (i == 4) ? 18'h3ffff : 18'($random(seed));
        req(adrc_pkg::ADRC_OP_WRITE, a, 16'($random(seed)), (be == 2'h0) ? 2'h3 : be);
        used.push_back(a);
      end
    end
    req(adrc_pkg::ADRC_OP_SELF_EXIT, 18'h00000, 16'h0000, 2'h0);
    repeat (5) @(negedge mclk_i);
    chk("exit_ignored", self_refresh_o, 1'b0);
    req(adrc_pkg::ADRC_OP_SELF_ENTER, 18'h00000, 16'h0000, 2'h0);
    repeat (20) @(negedge mclk_i);
    chk("self_entered", self_refresh_o, 1'b1);
    req(adrc_pkg::ADRC_OP_SELF_EXIT, 18'h00000, 16'h0000, 2'h0);
    repeat (30) @(negedge mclk_i);
    chk("self_left", self_refresh_o, 1'b0);
    foreach (used[k]) req(adrc_pkg::ADRC_OP_READ, used[k], 16'h0000, 2'h0);
    req(adrc_pkg::ADRC_OP_SELF_ENTER, 18'h00000, 16'h0000, 2'h0);
    repeat (20) @(negedge mclk_i);
    chk("reentry_refused", self_refresh_o, 1'b0);
    repeat (1000) @(negedge mclk_i);
    report_and_stop();
  end
endmodule : testbench
bind adrc_ctrl adrc_ctrl_monitor adrc_ctrl_monitor_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
  .req_valid_i(req_valid_i), .req_op_i(req_op_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
  .init_done_o(init_done_o), .self_refresh_o(self_refresh_o), .ras_n_o(ras_n_o), .cas_n_o(cas_n_o),
  .upper_byte_write_n_o(upper_byte_write_n_o), .lower_byte_write_n_o(lower_byte_write_n_o), .oe_n_o(oe_n_o),
  .dq_oe_o(dq_oe_o));
`default_nettype wire
